//--- rtl/ssoc_ctrl.sv
// Select, pipeline, burst order and output control of a synchronous SRAM
// Assumes the array port answers a read in the cycle after its request
//
// What this block does
// RULE1 - Selected only when both low enables low
// RULE2 - Disabled enable on load starts deselect
// RULE3 - Bus floats two cycles after deselect
// RULE4 - High enable acts alike, opposite polarity
// RULE5 - All timing on rising edge, except output enable
// RULE6 - Write and read data registered on edge
// RULE7 - Order select high interleaves, low linear
// RULE8 - Controller keeps order select static
// RULE9 - Read data shown only with output enable low
// RULE10 - Output enable high floats bus at once
// RULE11 - Direction managed inside; enable may stay low
// RULE12 - Load takes address; advance steps counter
// RULE13 - Data moves two cycles after load
// RULE14 - Clock enable high freezes everything
// RULE15 - Four beats, xor or add, then wrap
// RULE16 - Deselect stops burst; advances are no-ops
`timescale 1ns/1ns
`default_nettype none
module ssoc_ctrl #(
  parameter int FIFO_DEPTH = ssoc_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable_n,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire logic advance_or_load,
  input wire logic read_write_sel,
  input wire logic [ssoc_pkg::BYTES-1:0] byte_write_n,
  input wire logic [ssoc_pkg::ADDR_W-1:0] address,
  input wire logic burst_order_sel,
  input wire logic output_enable_n,
  input wire logic [ssoc_pkg::DATA_W-1:0] dataIn,
  output logic [ssoc_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic arrRdEn,
  output logic [ssoc_pkg::ADDR_W-1:0] arrRdAddr,
  input wire logic [ssoc_pkg::DATA_W-1:0] arrRdData,
  output logic arrWrValid,
  input wire logic arrWrReady,
  output ssoc_pkg::ssoc_wr_s arrWr,
  output logic writeFifoReady,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode

  ssoc_pkg::ssoc_state_e stQ;
  ssoc_pkg::ssoc_state_e stD;
  ssoc_pkg::ssoc_op_s opQ;
  ssoc_pkg::ssoc_op_s opD;
  ssoc_pkg::ssoc_op_s pipeQ;
  ssoc_pkg::ssoc_wr_s pushData;
  logic [ssoc_pkg::ADDR_W-1:0] baseQ;
  logic [1:0] idxQ;
  logic [1:0] idxD;
  logic [1:0] baseLow;
  logic [1:0] beatLow;
  logic dirWriteQ;
  logic driveQ;
  logic [ssoc_pkg::DATA_W-1:0] dataOutQ;
  logic wrEnQ;
  logic ovfQ;
  logic [31:0] loadsQ;
  logic waitQ;
  logic [31:0] rdDataQ;
  logic fifoInReady;

  // Low clock enable runs the block; high freezes every register
  wire en = ~clock_enable_n; // RULE14 RULE5
  wire selNow = ~select_low_a & ~select_low_b & select_high; // RULE1 RULE4
  wire loadCyc = ~advance_or_load;
  wire startOp = en & loadCyc & selNow; // RULE12
  wire deselect = en & loadCyc & ~selNow; // RULE2
  wire inBurst = (stQ == ssoc_pkg::ST_BURST);
  wire advOp = en & advance_or_load & inBurst; // RULE12
  wire noOp = en & advance_or_load & ~inBurst; // RULE16

  ////////////////////////////////////////////////////////////////////////////
  // Burst state

  always_comb begin
    stD = stQ;
    case (stQ)
      ssoc_pkg::ST_IDLE: begin
        if (startOp) begin
          stD = ssoc_pkg::ST_BURST;
        end
      end
      ssoc_pkg::ST_BURST: begin
        if (deselect) begin
          stD = ssoc_pkg::ST_DESEL; // RULE16
        end
      end
      ssoc_pkg::ST_DESEL: begin
        if (startOp) begin
          stD = ssoc_pkg::ST_BURST;
        end else if (noOp) begin
          stD = ssoc_pkg::ST_IDLE;
        end
      end
      default: begin
        stD = ssoc_pkg::ST_IDLE;
      end
    endcase
  end

  // A load restarts the count; an advance steps it, wrapping past four
  assign idxD = startOp ? 2'h0 : 2'(idxQ + 2'h1); // RULE15
  assign baseLow = startOp ? address[1:0] : baseQ[1:0];

  // Order select is read live; the controller must not move it
  ssoc_burst u_burst (
    .base(baseLow),
    .step(idxD),
    .interleave(burst_order_sel), // RULE8
    .low(beatLow)
  );

  // The external address is ignored while advancing
  always_comb begin
    opD.valid = startOp | advOp;
    opD.write = startOp ? ~read_write_sel : dirWriteQ;
    opD.addr = startOp ? address : baseQ; // RULE12
    opD.addr[1:0] = beatLow; // RULE7 RULE15
    opD.be = ~byte_write_n;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stQ <= ssoc_pkg::ST_IDLE;
      baseQ <= '0;
      idxQ <= 2'h0;
      dirWriteQ <= 1'b0;
    end else if (en) begin
      stQ <= stD;
      if (startOp) begin
        baseQ <= address;
        dirWriteQ <= ~read_write_sel;
      end
      if (startOp | advOp) begin
        idxQ <= idxD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two stage data pipeline

  // Stage one issues the array read at once, stage two moves data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opQ <= '0;
      pipeQ <= '0;
      arrRdEn <= 1'b0;
      arrRdAddr <= '0;
    end else if (en) begin
      opQ <= opD; // RULE13
      pipeQ <= opQ; // RULE13
      arrRdEn <= opD.valid & ~opD.write;
      arrRdAddr <= opD.addr;
    end
  end

  // Drive only for reads; a write loaded right after a read has its data sampled while that read still drives
  wire rdBeat = pipeQ.valid & ~pipeQ.write; // RULE11
  wire wrBeat = pipeQ.valid & pipeQ.write;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      driveQ <= 1'b0;
      dataOutQ <= '0;
    end else if (en) begin
      driveQ <= rdBeat; // RULE3 RULE16
      if (rdBeat) begin
        dataOutQ <= arrRdData; // RULE6
      end
    end
  end

  assign dataOut = dataOutQ;
  // Output enable bypasses the clock so it can float the bus any time
  assign dataOe = driveQ & ~output_enable_n; // RULE9 RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer; a full buffer drops the beat and flags overflow

  wire pushReq = en & wrBeat & wrEnQ;
  wire overflow = pushReq & ~fifoInReady;

  always_comb begin
    pushData.addr = pipeQ.addr;
    pushData.be = pipeQ.be;
    pushData.data = dataIn; // RULE6
  end

  ssoc_fifo #(
    .W($bits(ssoc_pkg::ssoc_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .en(en),
    .inValid(pushReq),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(arrWrValid),
    .outReady(arrWrReady),
    .outData(arrWr)
  );

  assign writeFifoReady = fifoInReady;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, one wait state per access

  wire req = avs_read | avs_write;
  wire done = en & req & ~waitQ;
  wire ofsCtrl = (avs_address == ssoc_pkg::OFS_CTRL);
  wire ofsStat = (avs_address == ssoc_pkg::OFS_STATUS);
  wire ofsLoads = (avs_address == ssoc_pkg::OFS_LOADS);
  wire wrCtrl = done & avs_write & ofsCtrl & avs_byteenable[0];
  wire wrStat = done & avs_write & ofsStat & avs_byteenable[0];
  wire ovfClr = wrStat & avs_writedata[ssoc_pkg::STAT_OVF_BIT];

  logic [31:0] ctrlWord;
  logic [31:0] statWord;
  logic [31:0] rdMux;

  always_comb begin
    ctrlWord = '0;
    ctrlWord[ssoc_pkg::CTRL_WREN_BIT] = wrEnQ;
    statWord = '0;
    statWord[ssoc_pkg::STAT_STATE_LSB +: 2] = stQ;
    statWord[ssoc_pkg::STAT_IDX_LSB +: 2] = idxQ;
    statWord[ssoc_pkg::STAT_DRIVE_BIT] = driveQ;
    statWord[ssoc_pkg::STAT_OVF_BIT] = ovfQ;
    statWord[ssoc_pkg::STAT_FIFO_RDY_BIT] = fifoInReady;
  end

  // Unmapped offsets read zero and ignore writes
  assign rdMux = ofsCtrl ? ctrlWord :
                 ofsStat ? statWord :
                 ofsLoads ? loadsQ : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitQ <= 1'b1;
      rdDataQ <= '0;
    end else if (en) begin
      waitQ <= ~(req & waitQ);
      if (req & waitQ) begin
        rdDataQ <= rdMux;
      end
    end
  end

  // Overflow set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrEnQ <= ssoc_pkg::CTRL_WREN_RST;
      ovfQ <= 1'b0;
      loadsQ <= '0;
    end else if (en) begin
      if (wrCtrl) begin
        wrEnQ <= avs_writedata[ssoc_pkg::CTRL_WREN_BIT];
      end
      if (overflow) begin
        ovfQ <= 1'b1;
      end else if (ovfClr) begin
        ovfQ <= 1'b0;
      end
      if (startOp) begin
        loadsQ <= loadsQ + 32'h0000_0001;
      end
    end
  end

  assign avs_waitrequest = waitQ;
  assign avs_readdata = rdDataQ;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence sLoadRead;
    startOp && read_write_sel;
  endsequence

  sequence sDeselect;
    deselect;
  endsequence

  sequence sTwoRun;
    en [*2];
  endsequence

  AST_SELECT: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    startOp |=> stQ == ssoc_pkg::ST_BURST && opQ.valid)
    else $error("Selected load did not start a burst");

  AST_HIGH_ENABLE: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    en && loadCyc && !select_high |=> !opQ.valid && !inBurst)
    else $error("Low active-high enable still selected");

  AST_DESELECT: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    sDeselect |=> !inBurst && !opQ.valid && !arrRdEn)
    else $error("Deselect left an operation running");

  AST_FLOAT_TWO: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    sDeselect ##1 sTwoRun |=> !driveQ)
    else $error("Bus still driven two cycles after deselect");

  AST_READ_TWO: assert property (@(posedge clock) disable iff (!rst_n) // RULE13
    sLoadRead ##1 sTwoRun |=> driveQ && dataOut == $past(arrRdData))
    else $error("Read data not out two cycles after load");

  AST_WRITE_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    en && wrBeat && wrEnQ && fifoInReady |-> u_fifo.push
      && pushData.data == dataIn && pushData.addr == pipeQ.addr)
    else $error("Write beat not captured");

  AST_OE_FLOAT: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    output_enable_n |-> !dataOe)
    else $error("Pins driven with output enable high");

  AST_OE_SHOW: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    !output_enable_n && driveQ |-> dataOe)
    else $error("Read data withheld with output enable low");

  AST_NO_FIGHT: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
    $rose(driveQ) |-> $past(pipeQ.valid) && !$past(pipeQ.write))
    else $error("Drive began without a read beat");

  AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
    !en |=> $stable(stQ) && $stable(driveQ) && $stable(dataOutQ)
      && $stable(opQ) && $stable(avs_waitrequest))
    else $error("State moved with clock enable high");

  AST_ADVANCE: assert property (@(posedge clock) disable iff (!rst_n) // RULE12
    advOp |=> idxQ == 2'($past(idxQ) + 2'h1) && $stable(baseQ))
    else $error("Advance did not step the counter");

  AST_ORDER: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    advOp && burst_order_sel |=> opQ.addr[1:0] == (baseQ[1:0] ^ idxQ))
    else $error("Interleaved beat address wrong");

  AST_WRAP: assert property (@(posedge clock) disable iff (!rst_n) // RULE15
    advOp && !burst_order_sel && idxQ == 2'h3 |=> opQ.addr[1:0] == baseQ[1:0])
    else $error("Linear burst did not wrap");

  AST_NOOP: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
    noOp |=> !opQ.valid && !arrRdEn && !inBurst)
    else $error("Advance after deselect was not a no-op");

  AST_EDGE_ONLY: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    en && !opD.valid |=> !opQ.valid)
    else $error("Operation appeared without a sampled cause");

endmodule // ssoc_ctrl
`default_nettype wire

//--- rtl/ssoc_pkg.sv
// Shared constants, states and carriers of the select and output block
// Assumes one clock for the pins, the array port and the register bus
package ssoc_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int BYTES = 4;
  localparam int FIFO_DEPTH = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LOADS = 4'h8;

  // Control fields
  localparam int CTRL_WREN_BIT = 0;
  localparam logic CTRL_WREN_RST = 1'b1;

  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IDX_LSB = 2;
  localparam int STAT_DRIVE_BIT = 4;
  localparam int STAT_OVF_BIT = 5;
  localparam int STAT_FIFO_RDY_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Gray coded along idle, burst, deselect
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BURST = 2'h1,
    ST_DESEL = 2'h3
  } ssoc_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0] be;
  } ssoc_op_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0] be;
    logic [DATA_W-1:0] data;
  } ssoc_wr_s;

endpackage

//--- rtl/ssoc_burst.sv
// Low address bits of one burst beat
// Assumes the step count is kept by the caller
`timescale 1ns/1ns
`default_nettype none
module ssoc_burst (
  input wire logic [1:0] base,
  input wire logic [1:0] step,
  input wire logic interleave,
  output logic [1:0] low
);

  // Interleave flips bits, linear adds and wraps at four
  assign low = interleave ? (base ^ step) : 2'(base + step); // RULE7 RULE15

endmodule // ssoc_burst
`default_nettype wire

//--- rtl/ssoc_fifo.sv
// Write buffer between the data pins and the array port
// Assumes DEPTH is a power of two; all state stalls while en is low
`timescale 1ns/1ns
`default_nettype none
module ssoc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic en,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtrQ;
  logic [PW-1:0] rdPtrQ;
  logic [PW:0] cntQ;
  logic [PW:0] cntD;

  wire push = en & inValid & inReady;
  wire pop = en & outValid & outReady;

  assign cntD = cntQ + (PW+1)'(push) - (PW+1)'(pop);
  assign outValid = (cntQ != '0);
  assign outData = mem[rdPtrQ];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtrQ] <= inData;
    end
  end

  // Ready is registered so the source sees a clean full flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      cntQ <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
      if (pop) begin
        rdPtrQ <= rdPtrQ + 1'b1;
      end
      cntQ <= cntD;
      inReady <= (cntD != (PW+1)'(DEPTH));
    end
  end

endmodule // ssoc_fifo
`default_nettype wire

//--- test/ssoc_array_model.sv
// Behavioural array behind the block's read and write ports
// Assumes reads answered one cycle after arrRdEn; stall holds write ready low
`timescale 1ns/1ns
`default_nettype none
module ssoc_array_model (
  input wire logic clock,
  input wire logic clock_enable_n,
  input wire logic arrRdEn,
  input wire logic [ssoc_pkg::ADDR_W-1:0] arrRdAddr,
  output logic [ssoc_pkg::DATA_W-1:0] arrRdData,
  input wire logic arrWrValid,
  output logic arrWrReady,
  input wire ssoc_pkg::ssoc_wr_s arrWr,
  input wire logic stall
);
  logic [ssoc_pkg::DATA_W-1:0] mem [int];

  // Unwritten words carry their own address twice
  function automatic logic [35:0] peek(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : {2'h2, a, a};
  endfunction

  initial begin
    arrRdData = '0;
    arrWrReady = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle read cycles toggle the data so a late sample never matches
  always @(posedge clock) begin
    arrWrReady <= !stall;
    if (!clock_enable_n) begin
      arrRdData <= arrRdEn ? peek(arrRdAddr) : ~arrRdData;
      if (arrWrValid && arrWrReady) begin
        automatic logic [35:0] w = peek(arrWr.addr);
        for (int i = 0; i < 4; i++) begin
          if (arrWr.be[i]) w[9*i+:9] = arrWr.data[9*i+:9];
        end
        mem[arrWr.addr] = w;
      end
    end
  end
endmodule // ssoc_array_model
`default_nettype wire

//--- test/ssoc_ctrl_test.sv
// Self-checking bench for the select and output block
// Assumes the array model answers reads; FIFO depth shortened to 4
`timescale 1ns/1ns
`default_nettype none
module ssoc_ctrl_test;
  logic clock, rst_n, clock_enable_n, select_low_a, select_low_b;
  logic select_high, advance_or_load, read_write_sel, burst_order_sel;
  logic output_enable_n, dataOe, arrRdEn, arrWrValid, arrWrReady;
  logic writeFifoReady, avs_read, avs_write, avs_waitrequest, stall;
  logic [3:0] byte_write_n, avs_address, avs_byteenable;
  logic [16:0] address, arrRdAddr;
  logic [35:0] dataIn, dataOut, arrRdData;
  logic [31:0] avs_writedata, avs_readdata, q;
  ssoc_pkg::ssoc_wr_s arrWr;
  int miscompares = 0, samples_checked = 0, n = 0, k = 0, loads = 0;
  int cycles = 0;
  bit chk [64];
  logic expOe [64];
  logic [35:0] expD [64], dinQ [64], lastOut;
  logic [35:0] shadow [int];
  logic [16:0] bAddr;
  logic act, isWr, keep, oeV, lastOe;
  logic [3:0] bwV;

  ssoc_ctrl #(.FIFO_DEPTH(4)) dut_u (.clock(clock), .rst_n(rst_n),
    .clock_enable_n(clock_enable_n), .select_low_a(select_low_a),
    .select_low_b(select_low_b), .select_high(select_high),
    .advance_or_load(advance_or_load), .read_write_sel(read_write_sel),
    .byte_write_n(byte_write_n), .address(address),
    .burst_order_sel(burst_order_sel), .output_enable_n(output_enable_n),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData),
    .arrWrValid(arrWrValid), .arrWrReady(arrWrReady), .arrWr(arrWr),
    .writeFifoReady(writeFifoReady), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  ssoc_array_model array_u (.clock(clock), .clock_enable_n(clock_enable_n),
    .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData),
    .arrWrValid(arrWrValid), .arrWrReady(arrWrReady), .arrWr(arrWr),
    .stall(stall));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  function automatic logic [35:0] peekS(input logic [16:0] a);
    return shadow.exists(a) ? shadow[a] : {2'h2, a, a};
  endfunction

  // Held until waitrequest is sampled low; data taken at that edge
  // No local limit: only the bench timeout may end a hung access
  task automatic avs(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // kind 0 load or deselect by sel, 1 advance, 2 suspended edge
  task automatic op(input int kind, input logic [16:0] a, input logic w,
                    input logic [2:0] sel, input logic [35:0] d);
    logic [16:0] ba;
    logic [35:0] cur;
    logic hit;
    hit = 1'b0;
    if (kind == 0 && sel == 3'h1) begin
      {act, isWr, bAddr, k, hit} = {2'b10 | w, a, 32'h0, 1'b1};
      loads++;
    end else if (kind == 0) act = 1'b0;
    else if (kind == 1 && act) begin
      k++;
      hit = 1'b1;
    end
    ba = {bAddr[16:2], burst_order_sel ? bAddr[1:0] ^ 2'(k)
                                       : bAddr[1:0] + 2'(k)};
    if (kind != 2) begin
      chk[(n+3)%64] = 1'b1;
      expOe[(n+3)%64] = hit && !isWr;
      expD[(n+3)%64] = peekS(ba);
      if (hit && isWr) begin
        dinQ[(n+2)%64] = d;
        cur = peekS(ba);
        for (int i = 0; i < 4; i++) begin
          if (!bwV[i]) cur[9*i+:9] = d[9*i+:9];
        end
        if (keep) shadow[ba] = cur;
      end
    end
    @(posedge clock);
    clock_enable_n <= (kind == 2);
    {select_low_a, select_low_b, select_high} <= sel;
    advance_or_load <= (kind == 1);
    read_write_sel <= !w;
    address <= a;
    byte_write_n <= bwV;
    output_enable_n <= oeV;
    dataIn <= dinQ[n%64];
    #1;
    if (kind == 2) begin
      check(dataOut, lastOut);
      check(dataOe, lastOe);
    end else begin
      dinQ[n%64] = ~dinQ[n%64];
      if (chk[n%64]) check(dataOe, expOe[n%64] & !oeV);
      if (chk[n%64] && expOe[n%64]) check(dataOut, expD[n%64]);
      chk[n%64] = 1'b0;
      n++;
    end
    {lastOut, lastOe} = {dataOut, dataOe};
  endtask

  task automatic idle(input int c);
    repeat (c) op(0, 17'h0_0000, 1'b0, 3'h0, 36'h0);
  endtask

  task automatic burst(input logic [16:0] a, input logic w, input int beats);
    op(0, a, w, 3'h1, {19'h0_1234, a});
    for (int i = 1; i < beats; i++) op(1, a, w, 3'h1, {19'h5_4321, a ^ 17'(i)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock_enable_n, select_low_a, select_low_b, select_high} = 4'h6;
    {advance_or_load, read_write_sel, burst_order_sel, output_enable_n} = 4'h4;
    {avs_read, avs_write, stall, act, isWr, oeV} = 6'h0;
    {byte_write_n, bwV, avs_address, avs_byteenable} = 16'h000f;
    {address, dataIn, avs_writedata, bAddr} = '0;
    foreach (dinQ[i]) dinQ[i] = 36'h9_6969_6969;
    keep = 1'b1;
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check(dataOe, 1'b0);
    check(writeFifoReady, 1'b1);
    avs(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h0000_0001);
    avs(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h0000_0000);
    idle(3);
    // Both orders from an odd base, five beats to show the wrap
    for (int b = 0; b < 2; b++) begin
      burst_order_sel <= b[0];
      idle(1);
      burst(17'h1_2341, 1'b0, 5);
      op(0, 17'h0_0000, 1'b0, 3'h3, 36'h0);
      op(1, 17'h0_0000, 1'b0, 3'h1, 36'h0);
      op(1, 17'h0_0000, 1'b0, 3'h1, 36'h0);
      idle(3);
    end
    // Each enable alone turned inactive ends a running burst
    for (int i = 0; i < 3; i++) begin
      burst(17'h0_0042, 1'b0, 2);
      op(0, 17'h0_0050, 1'b0, 3'h1 ^ 3'(1 << i), 36'h0);
      op(1, 17'h0_0000, 1'b0, 3'h1, 36'h0);
      idle(3);
    end
    // Writes and reads back to back with output enable low, then a read burst with it high, and suspended edges with it low
    burst(17'h0_0a00, 1'b1, 1);
    burst(17'h0_0b00, 1'b0, 1);
    bwV = 4'ha;
    burst(17'h0_0c00, 1'b1, 2);
    bwV = 4'h0;
    idle(8);
    burst(17'h0_0a00, 1'b0, 1);
    burst(17'h0_0c00, 1'b0, 2);
    idle(3);
    oeV = 1'b1;
    burst(17'h0_0b02, 1'b0, 4);
    idle(3);
    oeV = 1'b0;
    burst(17'h0_0d00, 1'b0, 1);
    repeat (2) op(2, 17'h0_0000, 1'b0, 3'h1, 36'h0);
    op(1, 17'h0_0000, 1'b0, 3'h1, 36'h0);
    op(2, 17'h0_0000, 1'b0, 3'h1, 36'h0);
    op(1, 17'h0_0000, 1'b0, 3'h1, 36'h0);
    idle(3);
    // Stalled array: the buffer fills with four beats and refuses the last four
    burst_order_sel <= 1'b0;
    stall = 1'b1;
    burst(17'h0_0100, 1'b1, 4);
    burst(17'h0_0104, 1'b1, 3);
    keep = 1'b0;
    op(1, 17'h0_0000, 1'b1, 3'h1, 36'h0);
    idle(4);
    keep = 1'b1;
    check(writeFifoReady, 1'b0);
    avs(1'b0, 4'h4, 32'h0, q);
    check(q & 32'h0000_0020, 32'h0000_0020);
    // Released by NBA: this line runs in the time step of an edge
    stall <= 1'b0;
    for (int t = 0; t < 100 && arrWrValid !== 1'b0; t++) @(posedge clock);
    #1;
    check(arrWrValid, 1'b0);
    check(writeFifoReady, 1'b1);
    avs(1'b1, 4'h4, 32'h0000_0020, q);
    avs(1'b0, 4'h4, 32'h0, q);
    check(q & 32'h0000_0060, 32'h0000_0040);
    burst(17'h0_0100, 1'b0, 4);
    burst(17'h0_0107, 1'b0, 1);
    idle(3);
    // Write beats dropped while the write enable is off
    avs(1'b1, 4'h0, 32'h0, q);
    keep = 1'b0;
    burst(17'h0_0200, 1'b1, 1);
    idle(6);
    keep = 1'b1;
    burst(17'h0_0200, 1'b0, 1);
    idle(3);
    avs(1'b1, 4'h0, 32'h0000_0001, q);
    avs(1'b1, 4'h8, 32'h0, q);
    avs(1'b0, 4'h8, 32'h0, q);
    check(q, 32'(loads));
    end_of_test();
  end
endmodule // ssoc_ctrl_test
`default_nettype wire
